// [bench/ssp_checker.sv]
// assertions on the serial port's register read port and serial pins
// assumes the ssp_port ports; control writes are shadowed from the bus
`timescale 1ns/100ps
`include "ssp_regs.vh"
module ssp_checker (
   input wire clk,
   input wire rst_b,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire serial_clock_pin_out,
   input wire serial_clock_pin_oe,
   input wire serial_data_out_pin
);
   reg [7:0] cr_r;
   reg [7:0] cr_d;
   reg up_r;
   wire sck = serial_clock_pin_out;
   wire same = up_r && cr_r[5:0] == cr_d[5:0];
   wire rsvd = cr_r[5:4] == `SSP_KIND_RSVD;
   wire halt_w = wr && addr == `SSP_ADDR_CONTROL && wdata[`SSP_CR_HALT];
   wire mapped = addr == `SSP_ADDR_CONTROL || addr == `SSP_ADDR_STATUS ||
      addr == `SSP_ADDR_BYTE_BUF;
   // a halt keeps the mode fields, so the shadow ignores it
   always @(posedge clk) begin
      if (!rst_b) begin
         cr_r <= 8'h00;
         cr_d <= 8'h00;
         up_r <= 1'b0;
      end else begin
         if (wr && addr == `SSP_ADDR_CONTROL) begin
            cr_r <= wdata;
         end
         cr_d <= cr_r;
         up_r <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_unmapped_zero: assert property (rd && !mapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_half_fc8: assert property (same && cr_r[2:0] == 3'b110 &&
      serial_clock_pin_oe && $fell(sck) |-> !sck [*4] ##1 sck)
      else $error("fc/8 low phase wrong");
   chk_half_fc16: assert property (same && cr_r[2:0] == 3'b101 &&
      serial_clock_pin_oe && $fell(sck) |-> !sck [*8] ##1 sck)
      else $error("fc/16 low phase wrong");
   chk_clock_drive: assert property (same |-> serial_clock_pin_oe ==
      (cr_r[2:0] != `SSP_CLK_EXT && !rsvd))
      else $error("serial clock enable wrong");
   chk_rsvd_quiet: assert property (same && rsvd |-> serial_data_out_pin)
      else $error("data moved in reserved kind");
   chk_halt_clear: assert property (halt_w ##2 rd &&
      addr == `SSP_ADDR_CONTROL |=> rdata[7:6] == 2'b00)
      else $error("halt or run bit still set");
   chk_halt_status: assert property (halt_w ##3 rd &&
      addr == `SSP_ADDR_STATUS |=> rdata == `SSP_SR_RESET)
      else $error("status not initial after halt");
   cover property (halt_w);
   cover property (same && cr_r[2:0] == 3'b101 && $fell(sck));
   cover property (same && rsvd && cr_r[7]);
endmodule
bind ssp_port ssp_checker i_chk (.clk, .rst_b, .addr, .wdata, .wr, .rd,
   .rdata, .serial_clock_pin_out, .serial_clock_pin_oe, .serial_data_out_pin);

// [bench/ssp_partner.sv]
// far-side serial device: 8-clock external frames on request, msb first
// assumes sck is the resolved clock wire; pulse widths are 5 clk each
`timescale 1ns/100ps
module ssp_partner (
   input wire clk,
   input wire go,
   input wire [7:0] tx_byte,
   input wire sck,
   input wire sdo,
   output reg sck_drv,
   output reg sdi,
   output reg [7:0] cap
);
   reg [6:0] ph = 7'h00;
   reg [3:0] n = 4'h0;
   reg sck_q = 1'b1;
   initial sdi = 1'b1;
   initial cap = 8'h00;
   // clock stands high between frames
   always @* sck_drv = ph == 7'h00 || ((ph - 7'h01) / 5) % 2 == 1;
   always @(posedge clk) begin
      sck_q <= sck;
      if (go && ph == 7'h00) begin
         ph <= 7'h01;
      end else if (ph != 7'h00) begin
         ph <= ph == 7'd80 ? 7'h00 : ph + 7'h01;
      end
      if (sck_q && !sck) begin
         sdi <= tx_byte[3'd7 - n[2:0]];
         n <= n + 4'h1;
      end else if (!sck_q && sck && n != 4'h0) begin
         cap <= {cap[6:0], sdo};
         n <= n == 4'h8 ? 4'h0 : n;
      end else if (n == 4'h0) begin
         // idle data line changes every cycle so stale bits are not seen
         sdi <= ~sdi;
      end
   end
endmodule

// [bench/tb.sv]
// register-level tests of the clocked serial port against a far-side model
// assumes ssp_port, ssp_checker and ssp_partner; fs runs at half of clk so
// that fs/16 bytes stay short
`timescale 1ns/100ps
`include "ssp_regs.vh"
module tb;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg go = 1'b0;
   reg fs = 1'b0;
   reg dsel = 1'b0;
   reg slow = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [7:0] wdata = 8'h00;
   reg [7:0] pb = 8'h00;
   reg [7:0] got;
   reg [7:0] cfg;
   reg [7:0] tx;
   wire [7:0] rdata;
   wire [7:0] cap;
   wire sck_o, sck_oe, sdo, sck_p, sdi;
   wire sck = sck_oe ? sck_o : sck_p;
   integer err_total = 0;
   integer n_tests = 0;
   integer k;
   always #50 clk = ~clk;
   always @(posedge clk) fs <= ~fs;
   ssp_port i_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .divider_select(dsel),
      .low_speed(slow), .fs_clk(fs), .serial_clock_pin_in(sck),
      .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
      .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));
   ssp_partner i_far (.clk(clk), .go(go), .tx_byte(pb), .sck(sck),
      .sdo(sdo), .sck_drv(sck_p), .sdi(sdi), .cap(cap));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // strobes are left high; the next call or idle drops them
   task wrr(input [7:0] a, input [7:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         rd <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rdd(input [7:0] a);
      begin
         addr <= a;
         wr <= 1'b0;
         rd <= 1'b1;
         @(posedge clk);
         #1 got = rdata;
      end
   endtask
   task idle;
      begin
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task poll(input integer b, input v);
      integer i;
      begin
         rdd(`SSP_ADDR_STATUS);
         for (i = 0; i < 3000 && got[b] !== v; i = i + 1) begin
            rdd(`SSP_ADDR_STATUS);
         end
         // a wait that runs out is a failure, not a silent fall-through
         if (got[b] !== v)
            err_total = err_total + 1;
      end
   endtask
   task frame;
      begin
         idle;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (90) @(posedge clk);
      end
   endtask
   function [7:0] rev(input [7:0] b);
      rev = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
   endfunction
   task end_of_test;
      begin
         if (err_total == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #3000000;
      err_total = err_total + 1;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rdd(`SSP_ADDR_CONTROL);
      chk(got, `SSP_CR_RESET);
      rdd(`SSP_ADDR_STATUS);
      chk(got, `SSP_SR_RESET);
      rdd(`SSP_ADDR_BYTE_BUF);
      chk(got, `SSP_RXBUF_RESET);
      rdd(8'h40);
      chk(got, 8'h00);
      for (k = 0; k < 2; k = k + 1) begin
         cfg = {2'b00, `SSP_KIND_BOTH, k[0], k[0] ? 3'b101 : 3'b110};
         tx = k[0] ? 8'h3c : 8'ha5;
         pb <= ~tx;
         wrr(`SSP_ADDR_CONTROL, cfg);
         poll(5, 1'b1);
         wrr(`SSP_ADDR_BYTE_BUF, tx);
         rdd(`SSP_ADDR_STATUS);
         chk(got[5], 1'b0);
         wrr(`SSP_ADDR_BYTE_BUF, ~tx);
         wrr(`SSP_ADDR_CONTROL, cfg | 8'h80);
         poll(6, 1'b1);
         chk(got[7], 1'b1);
         poll(4, 1'b1);
         chk(got[5], 1'b1);
         wrr(`SSP_ADDR_CONTROL, cfg);
         poll(7, 1'b0);
         chk(got[6], 1'b0);
         rdd(`SSP_ADDR_BYTE_BUF);
         chk(got, k[0] ? rev(~tx) : ~tx);
         rdd(`SSP_ADDR_STATUS);
         chk(got[4], 1'b0);
         chk(cap, k[0] ? rev(tx) : tx);
         chk(sck, 1'b1);
      end
      wrr(`SSP_ADDR_CONTROL, 8'h07);
      wrr(`SSP_ADDR_CONTROL, 8'h87);
      frame;
      chk(cap, 8'hff);
      rdd(`SSP_ADDR_STATUS);
      chk(got[3], 1'b1);
      wrr(`SSP_ADDR_STATUS, 8'hff);
      wrr(`SSP_ADDR_CONTROL, 8'h07);
      rdd(`SSP_ADDR_STATUS);
      chk(got[3], 1'b1);
      wrr(`SSP_ADDR_STATUS, 8'h00);
      rdd(`SSP_ADDR_STATUS);
      chk(got[3], 1'b0);
      pb <= 8'hc3;
      wrr(`SSP_ADDR_CONTROL, 8'h17);
      wrr(`SSP_ADDR_CONTROL, 8'h97);
      frame;
      frame;
      rdd(`SSP_ADDR_STATUS);
      chk(got[4:2], 3'b101);
      rdd(`SSP_ADDR_BYTE_BUF);
      chk(got, 8'hc3);
      wrr(`SSP_ADDR_CONTROL, 8'hd7);
      rdd(`SSP_ADDR_CONTROL);
      rdd(`SSP_ADDR_CONTROL);
      chk(got, 8'h17);
      rdd(`SSP_ADDR_STATUS);
      chk(got, `SSP_SR_RESET);
      rdd(`SSP_ADDR_BYTE_BUF);
      chk(got, `SSP_RXBUF_RESET);
      wrr(`SSP_ADDR_CONTROL, 8'hb6);
      idle;
      repeat (100) @(posedge clk);
      chk({sck_oe, sdo, sck_o}, 8'h03);
      wrr(`SSP_ADDR_CONTROL, 8'h00);
      // code 000 through fs/16, once by divider select, once by low speed
      for (k = 0; k < 2; k = k + 1) begin
         {slow, dsel} <= k[0] ? 2'b10 : 2'b01;
         tx = k[0] ? 8'h69 : 8'h96;
         wrr(`SSP_ADDR_BYTE_BUF, tx);
         wrr(`SSP_ADDR_CONTROL, 8'h80);
         poll(5, 1'b1);
         poll(6, 1'b0);
         chk(cap, tx);
         wrr(`SSP_ADDR_CONTROL, 8'h00);
         poll(7, 1'b0);
      end
      idle;
      end_of_test;
   end
endmodule

// [design/ssp_port.v]
// clocked 8-bit serial port: control, status, byte buffers and shift engine.
// assumes all inputs synchronous to clk; fs_clk is sampled and edge-detected,
// and an external serial clock must stay at each level at least 4 clk cycles.
`timescale 1ns/100ps
`include "ssp_regs.vh"

module ssp_port (
   input wire clk,
   input wire rst_b,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire divider_select,
   input wire low_speed,
   input wire fs_clk,
   input wire serial_clock_pin_in,
   output reg serial_clock_pin_out,
   output reg serial_clock_pin_oe,
   input wire serial_data_in_pin,
   output reg serial_data_out_pin
);

   reg run_r;
   reg halt_r;
   reg [1:0] kind_r;
   reg order_r;
   reg [2:0] clk_sel_r;
   reg active_r;
   reg partial_r;
   reg tx_empty_r;
   reg rx_full_r;
   reg send_fault_r;
   reg recv_fault_r;
   reg [7:0] rx_buf_r;
   reg [7:0] tx_buf_r;
   reg [7:0] shift_r;
   reg [3:0] bit_cnt_r;
   reg busy_r;
   reg sck_int_r;
   reg ext_sck_prev_r;
   reg fs_prev_r;
   reg [2:0] fs_cnt_r;
   reg [`SSP_DIV_W-1:0] div_r;

   reg [`SSP_DIV_W-1:0] half_mask;
   reg int_tick;
   wire ext_mode;
   wire kind_ok;
   wire tx_mode;
   wire rx_mode;
   wire fs_rise;
   wire ext_fall;
   wire ext_rise;
   wire int_start;
   wire int_fall;
   wire int_rise;
   wire ext_start;
   wire fall_ev;
   wire rise_ev;
   wire start_ev;
   wire byte_done;
   wire out_bit;
   wire [7:0] shifted;
   wire wr_buf;
   wire rd_buf;
   wire wr_ctrl;
   wire wr_stat;

   assign wr_buf = wr && (addr == `SSP_ADDR_BYTE_BUF);
   assign rd_buf = rd && (addr == `SSP_ADDR_BYTE_BUF);
   assign wr_ctrl = wr && (addr == `SSP_ADDR_CONTROL);
   assign wr_stat = wr && (addr == `SSP_ADDR_STATUS);

   assign ext_mode = (clk_sel_r == `SSP_CLK_EXT); // R7
   assign kind_ok = (kind_r != `SSP_KIND_RSVD); // R21
   assign tx_mode = (kind_r == `SSP_KIND_SEND) || (kind_r == `SSP_KIND_BOTH);
   assign rx_mode = (kind_r == `SSP_KIND_RECV) || (kind_r == `SSP_KIND_BOTH);

   // clock rate selection; reserved low-speed codes never tick
   always @* begin
      half_mask = `SSP_HALF_12;
      case (clk_sel_r) // R6
         3'h0: half_mask = `SSP_HALF_12;
         3'h1: half_mask = `SSP_HALF_8;
         3'h2: half_mask = `SSP_HALF_7;
         3'h3: half_mask = `SSP_HALF_6;
         3'h4: half_mask = `SSP_HALF_5;
         3'h5: half_mask = `SSP_HALF_4;
         3'h6: half_mask = `SSP_HALF_3;
         default: half_mask = `SSP_HALF_3;
      endcase
   end

   assign fs_rise = fs_clk && !fs_prev_r;

   always @* begin
      int_tick = 1'b0;
      if (ext_mode) begin
         int_tick = 1'b0;
      end else if (clk_sel_r == `SSP_CLK_SLOW &&
                   (divider_select || low_speed)) begin
         int_tick = fs_rise && (fs_cnt_r == `SSP_FS_HALF); // R6
      end else if (!low_speed) begin
         int_tick = ((div_r & half_mask) == half_mask); // R6
      end
   end

   // internal clock: a byte starts only when its buffers allow, which is
   // the automatic wait; the clock idles high while not busy
   assign int_start = !ext_mode && !busy_r && run_r && kind_ok && int_tick &&
                      !(tx_mode && tx_empty_r) && !(rx_mode && rx_full_r);
   assign int_fall = int_start || (busy_r && int_tick && sck_int_r);
   assign int_rise = busy_r && int_tick && !sck_int_r;

   // external clock edges come straight from the pin, already synchronous
   assign ext_fall = ext_mode && ext_sck_prev_r && !serial_clock_pin_in;
   assign ext_rise = ext_mode && !ext_sck_prev_r && serial_clock_pin_in;
   assign ext_start = ext_fall && !busy_r && run_r && kind_ok; // R1

   assign start_ev = int_start || ext_start;
   assign fall_ev = int_fall || (ext_fall && (busy_r || ext_start));
   assign rise_ev = int_rise || (ext_rise && busy_r);
   assign byte_done = rise_ev && (bit_cnt_r == `SSP_BITS_PER_BYTE - 4'h1);

   // the first bit comes from the buffer itself on the starting edge
   assign out_bit = order_r ? (start_ev ? tx_buf_r[0] : shift_r[0]) :
                    (start_ev ? tx_buf_r[7] : shift_r[7]); // R5
   assign shifted = order_r ? {serial_data_in_pin, shift_r[7:1]} :
                    {shift_r[6:0], serial_data_in_pin}; // R5

   always @(posedge clk) begin
      if (!rst_b) begin
         run_r <= 1'b0;
         halt_r <= 1'b0;
         kind_r <= 2'b00;
         order_r <= 1'b0;
         clk_sel_r <= 3'h0;
         active_r <= 1'b0;
         partial_r <= 1'b0;
         tx_empty_r <= 1'b1;
         rx_full_r <= 1'b0;
         send_fault_r <= 1'b0;
         recv_fault_r <= 1'b0;
         rx_buf_r <= `SSP_RXBUF_RESET;
         tx_buf_r <= 8'h00;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         busy_r <= 1'b0;
         sck_int_r <= 1'b1;
         ext_sck_prev_r <= 1'b1;
         fs_prev_r <= 1'b0;
         fs_cnt_r <= 3'h0;
         div_r <= {`SSP_DIV_W{1'b0}};
         rdata <= 8'h00;
         serial_clock_pin_out <= 1'b1;
         serial_clock_pin_oe <= 1'b0;
         serial_data_out_pin <= 1'b1;
      end else begin
         div_r <= div_r + {{(`SSP_DIV_W-1){1'b0}}, 1'b1};
         fs_prev_r <= fs_clk;
         if (fs_rise)
            fs_cnt_r <= fs_cnt_r + 3'h1;
         ext_sck_prev_r <= serial_clock_pin_in;

         // read data stand one cycle after the strobe
         rdata <= 8'h00;
         if (rd && addr == `SSP_ADDR_BYTE_BUF) begin
            rdata <= rx_buf_r; // R16
         end else if (rd && addr == `SSP_ADDR_CONTROL) begin
            rdata <= {run_r, halt_r, kind_r, order_r, clk_sel_r};
         end else if (rd && addr == `SSP_ADDR_STATUS) begin
            rdata <= {active_r, partial_r, tx_empty_r, rx_full_r,
                      send_fault_r, recv_fault_r, 2'b00};
         end

         if (halt_r) begin
            // halt applies one cycle after the write, then clears itself
            halt_r <= 1'b0; // R2
            run_r <= 1'b0; // R3
            active_r <= 1'b0; // R3
            partial_r <= 1'b0; // R3
            tx_empty_r <= 1'b1; // R3
            rx_full_r <= 1'b0; // R3
            send_fault_r <= 1'b0; // R3
            recv_fault_r <= 1'b0; // R3
            rx_buf_r <= `SSP_RXBUF_RESET; // R3
            tx_buf_r <= 8'h00; // R3
            bit_cnt_r <= 4'h0; // R2
            busy_r <= 1'b0; // R2
            sck_int_r <= 1'b1;
            serial_clock_pin_out <= 1'b1;
            serial_data_out_pin <= 1'b1;
         end else begin
            if (wr_ctrl) begin
               run_r <= wdata[`SSP_CR_RUN]; // R1
               halt_r <= wdata[`SSP_CR_HALT]; // R2
               kind_r <= wdata[`SSP_CR_KIND_HI:`SSP_CR_KIND_LO]; // R4
               order_r <= wdata[`SSP_CR_ORDER]; // R5
               clk_sel_r <= wdata[`SSP_CR_CLK_HI:`SSP_CR_CLK_LO]; // R6
            end

            // transmit buffer: accepted only while empty
            if (wr_buf && tx_empty_r) begin // R18
               tx_buf_r <= wdata; // R16
               tx_empty_r <= 1'b0; // R11
            end
            if (start_ev && tx_mode && !tx_empty_r)
               tx_empty_r <= 1'b1; // R11

            // receive buffer read frees it; a byte landing now wins
            if (rd_buf)
               rx_full_r <= 1'b0; // R12

            // fault flags: zero write clears, a new fault wins
            if (wr_stat && !wdata[`SSP_SR_SEND_FAULT])
               send_fault_r <= 1'b0; // R13
            if (wr_stat && !wdata[`SSP_SR_RECV_FAULT])
               recv_fault_r <= 1'b0; // R14
            if (ext_start && tx_mode && tx_empty_r)
               send_fault_r <= 1'b1; // R13

            if (start_ev) begin
               busy_r <= 1'b1;
               active_r <= 1'b1; // R9
               bit_cnt_r <= 4'h0;
               shift_r <= tx_buf_r;
            end
            if (fall_ev) begin
               partial_r <= 1'b1; // R10
               if (!ext_mode)
                  sck_int_r <= 1'b0;
               // send fault and receive-only hold the data line high
               if (tx_mode && !(ext_start && tx_empty_r) && !send_fault_r)
                  serial_data_out_pin <= out_bit;
               else
                  serial_data_out_pin <= 1'b1;
            end
            if (rise_ev) begin
               if (!ext_mode)
                  sck_int_r <= 1'b1; // R20
               shift_r <= shifted;
               bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (byte_done) begin
               busy_r <= 1'b0;
               partial_r <= 1'b0; // R10
               bit_cnt_r <= 4'h0;
               if (rx_mode) begin
                  if (rx_full_r && !rd_buf && ext_mode) begin
                     recv_fault_r <= 1'b1; // R14
                  end else if (!recv_fault_r) begin
                     // buffer stays protected while the overrun stands
                     rx_buf_r <= shifted;
                     rx_full_r <= 1'b1; // R12
                  end
               end
            end
            // finished once idle with no run request; faults untouched
            if (!run_r && !busy_r && !start_ev)
               active_r <= 1'b0; // R9 R15

            serial_clock_pin_oe <= !ext_mode && kind_ok; // R7 R21
            if (ext_mode)
               serial_clock_pin_out <= 1'b1;
            else if (fall_ev)
               serial_clock_pin_out <= 1'b0;
            else if (rise_ev)
               serial_clock_pin_out <= 1'b1; // R20
            if (!busy_r && !start_ev && !fall_ev)
               serial_data_out_pin <= 1'b1;
         end
      end
   end

endmodule

// [design/ssp_regs.vh]
// register offsets, field positions, reset values and clock dividers of the
// clocked serial port; included by the port's design file.
//
// Function
// (R1) run-request one starts transfers, zero stops them after the current byte
// (R2) forced-halt one aborts at once and clears itself after taking effect
// (R3) forced halt resets run-request, status, receive and transmit buffers
// (R4) transfer-kind 00 send, 01 receive, 10 both, 11 reserved
// (R5) bit-order zero shifts from bit 7, one from bit 0, both directions
// (R6) clock-select 000..110 picks fc/2^12..fc/2^3, or fs/2^4 selections
// (R7) clock-select 111 shifts on the clock driven into the serial-clock pin
// (R8) software changes kind, order and clock only while transfer-active is zero
// (R9) transfer-active reads one while transfers run, zero once finished
// (R10) partial-byte reads one during clocks one to seven of a byte; the code keeps it one until the rising edge of clock eight
// (R11) transmit-empty reads one when the transmit buffer holds nothing
// (R12) receive-full reads one while the receive buffer holds unread data
// (R13) send-fault sets on external-clock underrun; write zero clears it
// (R14) receive-fault sets on external-clock overrun; write zero clears it
// (R15) clearing run-request leaves both fault bits as they are
// (R16) receive buffer read-only, transmit buffer write-only, one shared address
// (R17) software avoids read-modify-write on the transmit buffer address
// (R18) transmit buffer write while not empty is discarded
// (R19) software checks transmit-empty before writing each byte
// (R20) internal clock: serial-clock output stays high between transfers
// (R21) reserved transfer-kind 11 gives no activity on the serial pins
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

`define SSP_ADDR_BYTE_BUF 8'h2b
`define SSP_ADDR_CONTROL 8'h31
`define SSP_ADDR_STATUS 8'h32

// control fields
`define SSP_CR_RUN 7
`define SSP_CR_HALT 6
`define SSP_CR_KIND_HI 5
`define SSP_CR_KIND_LO 4
`define SSP_CR_ORDER 3
`define SSP_CR_CLK_HI 2
`define SSP_CR_CLK_LO 0
`define SSP_CR_RESET 8'h00

// status fields, bits 1:0 read as zero
`define SSP_SR_ACTIVE 7
`define SSP_SR_PARTIAL 6
`define SSP_SR_TX_EMPTY 5
`define SSP_SR_RX_FULL 4
`define SSP_SR_SEND_FAULT 3
`define SSP_SR_RECV_FAULT 2
`define SSP_SR_RESET 8'h20
`define SSP_RXBUF_RESET 8'h00

// transfer kinds
`define SSP_KIND_SEND 2'b00
`define SSP_KIND_RECV 2'b01
`define SSP_KIND_BOTH 2'b10
`define SSP_KIND_RSVD 2'b11

// clock-select codes
`define SSP_CLK_EXT 3'b111
`define SSP_CLK_SLOW 3'b000

// half-period masks of fc/2^n: toggle every 2^(n-1) fc cycles
`define SSP_DIV_W 12
`define SSP_HALF_12 12'h7ff
`define SSP_HALF_8 12'h07f
`define SSP_HALF_7 12'h03f
`define SSP_HALF_6 12'h01f
`define SSP_HALF_5 12'h00f
`define SSP_HALF_4 12'h007
`define SSP_HALF_3 12'h003
// fs/2^4: toggle every 8 fs periods
`define SSP_FS_HALF 3'h7
`define SSP_BITS_PER_BYTE 4'h8

`endif
